/* design/sbc_mode_controller.v */
/*
 * Mode state machine of a system basis chip with wake-up
 * detection, reset hold, access blocking, supply and
 * transceiver enables, bus bias and limp-home output.
 * Assumes async pin inputs; the register port is
 * synchronous to clk.
 */
// Our own choices: strobed register access and the register offsets.
// Contract
// RULE1 - One state machine with seven modes, Off to Forced Normal.
// RULE2 - Normal: main regulator on, all functions may be activated.
// RULE3 - Normal: bus may be active, watchdog window or timeout by config.
// RULE4 - Standby: no transmit or receive; serial port and regulator stay on.
// RULE5 - Standby: watchdog, if enabled, runs only in timeout mode.
// RULE6 - Remote wake enable set: receiver watches bus for wake in low power.
// RULE7 - Bias bus to ground after silence timeout, to 2.5 V on activity.
// RULE8 - Selective wake only when both partial net bits set, else pattern.
// RULE9 - Receive output forced low on any enabled wake-up event.
// RULE10 - Sleep: main regulator off, temperature protection off.
// RULE11 - Sleep is left on any enabled regular or diagnostic wake-up; code wakes on bus or local events only.
// RULE12 - Sleep: serial port and watchdog off, bus biasing still active.
// RULE13 - Sleep lockout bit set disables Sleep mode permanently; code blocks Sleep only while the sleep_lockout input is high.
// RULE14 - With lockout, sleep command flags serial failure, no Sleep.
// RULE15 - Reset mode holds reset line low for a defined duration.
// RULE16 - Reset: serial port and watchdog off, regulator and thermal on.
// RULE17 - Reset: aux supply follows its control and start-up bits.
// RULE18 - Standby and Sleep: aux supply follows its register setting.
// RULE19 - Host waits the access timeout after reset line rises.
// RULE20 - Early accesses ignored without a serial failure event.
// RULE21 - Receive output carries bus data and wake-up indication.
// RULE22 - Limp-home output is active-low open-drain.
// RULE23 - Mode field bits 2:0 at 0x01; 001 Sleep, 100 Standby.
// RULE24 - From Off, power-on detect leads to Reset after start-up time.
// RULE25 - Timeouts are oscillator counters with parameter lengths.
// RULE26 - Wake keeps receive output low until host clears the event.
`timescale 1ns/100ps
`include "sbc_mode_consts.vh"

module sbc_mode_controller #(
    parameter [31:0] STARTUP_CYC =
        (`T_STARTUP_US * 1000 + `CLK_NS - 1) / `CLK_NS,
    parameter [31:0] RESET_HOLD_CYC =
        (`T_RESET_HOLD_US * 1000 + `CLK_NS - 1) / `CLK_NS,
    parameter [31:0] SILENCE_CYC =
        (`T_SILENCE_US * 1000 + `CLK_NS - 1) / `CLK_NS
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire power_on_det,
    input wire overtemp_shut,
    input wire overtemp_warn,
    input wire reset_line_n_in,
    input wire bus_rx,
    input wire wake_pin,
    input wire frame_match,
    input wire sleep_lockout,
    input wire forced_normal_cfg,
    output reg rxd,
    output reg reset_line_n_out,
    output reg reset_line_n_oe,
    output reg limp_n_out,
    output reg limp_n_oe,
    output reg main_regulator_en,
    output reg aux_supply_en,
    output reg can_tx_en,
    output reg can_rx_en,
    output reg bus_bias_2v5,
    output reg watchdog_en,
    output reg watchdog_window,
    output reg spi_enable,
    output reg temp_protect_en,
    output reg [2:0] mode_state
);

    // ****************************************************************
    // States and derived counts
    // ****************************************************************
    localparam [2:0] ST_OFF = 3'h0; // RULE1
    localparam [2:0] ST_RESET = 3'h1;
    localparam [2:0] ST_STANDBY = 3'h2;
    localparam [2:0] ST_NORMAL = 3'h3;
    localparam [2:0] ST_SLEEP = 3'h4;
    localparam [2:0] ST_OVERTEMP = 3'h5;
    localparam [2:0] ST_FORCED = 3'h6;
    localparam [31:0] ACCESS_TO_CYC =
        (`T_ACCESS_TO_NS + `CLK_NS - 1) / `CLK_NS;
    localparam [31:0] WAKE_DOM_CYC =
        (`T_WAKE_DOM_NS + `CLK_NS - 1) / `CLK_NS;

    // Low-power modes
    function low_power;
        input [2:0] st;
        begin
            low_power = (st == ST_STANDBY) || (st == ST_SLEEP);
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    reg [8:0] sync1;
    reg [8:0] sync2;
    reg [8:0] prev;

    // Two stages per pin
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= `RST_SYNC;
            sync2 <= `RST_SYNC;
            prev <= `RST_SYNC;
        end else begin
            sync1 <= {forced_normal_cfg, sleep_lockout, frame_match,
                      bus_rx, reset_line_n_in, wake_pin, overtemp_warn,
                      overtemp_shut, power_on_det};
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    wire s_pon = sync2[0];
    wire s_ot_shut = sync2[1];
    wire warn_rise = sync2[2] & ~prev[2];
    wire wake_rise = sync2[3] & ~prev[3];
    wire s_rst_in_n = sync2[4];
    wire s_bus = sync2[5];
    wire match_rise = sync2[6] & ~prev[6];
    wire s_lockout = sync2[7];
    wire s_forced_cfg = sync2[8];

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg [2:0] state;
    reg [2:0] next_state;
    reg [2:0] mode_select;
    reg [1:0] wdog_cfg;
    reg [4:0] can_cfg;
    reg [2:0] aux_cfg;
    reg [4:0] events;
    reg [2:0] event_en;
    reg [31:0] mode_timer;
    reg [31:0] access_timer;
    reg [31:0] silence_cnt;
    reg [31:0] dom_cnt;

    wire remote_wake_enable = can_cfg[`CAN_REMOTE_WAKE];
    wire partial_net_config = can_cfg[`CAN_PN_CONFIG];
    wire partial_net_valid = can_cfg[`CAN_PN_VALID];
    wire can_active = (can_cfg[1:0] == `CAN_MODE_ACTIVE);
    wire [1:0] aux_supply_control = aux_cfg[1:0];
    wire aux_supply_startup_control = aux_cfg[`AUX_STARTUP];

    // Port open, timeout over
    wire port_up = (state == ST_STANDBY) || (state == ST_NORMAL) ||
                   (state == ST_FORCED);
    wire access_ok = port_up && (access_timer == 32'h0); // RULE20
    wire wr_ok = wr && access_ok && (state != ST_FORCED);
    wire mode_wr = wr_ok && (addr == `REG_MODE_CTRL); // RULE23

    // Mode commands
    wire cmd_sleep = mode_wr && (wdata[2:0] == `MODE_CMD_SLEEP);
    wire cmd_standby = mode_wr && (wdata[2:0] == `MODE_CMD_STANDBY);
    wire cmd_normal = mode_wr && (wdata[2:0] == `MODE_CMD_NORMAL);
    wire cmd_bad = mode_wr && !cmd_sleep && !cmd_standby && !cmd_normal;
    wire sleep_refused = cmd_sleep && s_lockout; // RULE13

    // ****************************************************************
    // Wake-up detection
    // ****************************************************************
    wire bus_watch = remote_wake_enable && (low_power(state) ||
                     (state == ST_NORMAL && !can_active)); // RULE6
    wire dom_hit = !s_bus && (dom_cnt == WAKE_DOM_CYC - 32'h1);
    wire pn_select = partial_net_config && partial_net_valid;
    wire bus_wake_set = bus_watch &&
                        (pn_select ? match_rise : dom_hit); // RULE8
    wire local_wake_set = event_en[`EV_LOCAL_WAKE] && wake_rise &&
                          (state != ST_OFF) && (state != ST_OVERTEMP);
    wire diag_set = event_en[`EV_OVERTEMP] && warn_rise &&
                    (state != ST_SLEEP) && (state != ST_OFF);
    wire fail_set = sleep_refused || cmd_bad; // RULE14
    wire limp_set = (state == ST_OVERTEMP);
    wire [4:0] ev_set = {limp_set, fail_set, diag_set, local_wake_set,
                         bus_wake_set};
    wire [4:0] ev_clr = (wr_ok && addr == `REG_EVENT) ? wdata[4:0] : 5'h0;
    wire wake_pending = |events[2:0]; // RULE9
    wire any_wake = bus_wake_set || local_wake_set || diag_set;

    // Dominant and silence counters
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dom_cnt <= 32'h0;
            silence_cnt <= 32'h0;
        end else begin
            if (s_bus)
                dom_cnt <= 32'h0;
            else if (dom_cnt != WAKE_DOM_CYC)
                dom_cnt <= dom_cnt + 32'h1;
            if (!s_bus)
                silence_cnt <= 32'h0; // RULE7
            else if (silence_cnt != SILENCE_CYC)
                silence_cnt <= silence_cnt + 32'h1;
        end
    end

    // ****************************************************************
    // Mode state machine
    // ****************************************************************
    // Next mode from pins, timers and commands
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (s_pon && mode_timer == STARTUP_CYC)
                    next_state = ST_RESET; // RULE24
            end
            ST_RESET: begin
                if (mode_timer >= RESET_HOLD_CYC && s_rst_in_n)
                    next_state = s_forced_cfg ? ST_FORCED : ST_STANDBY;
            end
            ST_STANDBY, ST_NORMAL: begin
                if (cmd_sleep && !s_lockout)
                    next_state = ST_SLEEP;
                else if (cmd_normal)
                    next_state = ST_NORMAL;
                else if (cmd_standby)
                    next_state = ST_STANDBY;
            end
            ST_SLEEP: begin
                if (any_wake)
                    next_state = ST_RESET; // RULE11
            end
            ST_OVERTEMP: begin
                if (!s_ot_shut)
                    next_state = ST_RESET;
            end
            ST_FORCED: begin
                next_state = ST_FORCED;
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        // Overrides: reset line, heat, power
        if ((state == ST_STANDBY || state == ST_NORMAL ||
             state == ST_FORCED) && !s_rst_in_n)
            next_state = ST_RESET;
        if (s_ot_shut && state != ST_OFF && state != ST_SLEEP)
            next_state = ST_OVERTEMP;
        if (!s_pon)
            next_state = ST_OFF;
    end

    // State register and mode timer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
            mode_timer <= 32'h0;
        end else begin
            state <= next_state;
            if (next_state != state || (state == ST_OFF && !s_pon))
                mode_timer <= 32'h0; // RULE25
            else if (mode_timer != 32'hFFFFFFFF)
                mode_timer <= mode_timer + 32'h1; // RULE15
        end
    end

    // Access timeout from Reset exit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            access_timer <= ACCESS_TO_CYC;
        else if (!port_up)
            access_timer <= ACCESS_TO_CYC; // RULE19
        else if (access_timer != 32'h0)
            access_timer <= access_timer - 32'h1; // RULE20
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    // Writes; sticky events, set wins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_select <= `RST_MODE_CTRL;
            wdog_cfg <= `RST_WDOG_CFG;
            can_cfg <= `RST_CAN_CFG;
            aux_cfg <= `RST_AUX_CFG;
            event_en <= `RST_EVENT_EN;
            events <= 5'h0;
        end else begin
            if (mode_wr && !fail_set)
                mode_select <= wdata[2:0];
            if (wr_ok && addr == `REG_WDOG_CFG)
                wdog_cfg <= wdata[1:0];
            if (wr_ok && addr == `REG_CAN_CFG)
                can_cfg <= wdata[4:0];
            if (wr_ok && addr == `REG_AUX_CFG)
                aux_cfg <= wdata[2:0];
            if (wr_ok && addr == `REG_EVENT_EN)
                event_en <= wdata[2:0];
            events <= (events & ~ev_clr) | ev_set; // RULE26
        end
    end

    // Read data next cycle, zero when blocked
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd && access_ok) begin
            case (addr)
                `REG_MODE_CTRL:
                    rdata <= (state == ST_FORCED) ? 8'h00 :
                             {5'h00, mode_select};
                `REG_MAIN_STAT:
                    rdata <= {4'h0, 1'b1, state};
                `REG_WDOG_CFG:
                    rdata <= (state == ST_FORCED) ? 8'h00 :
                             {6'h00, wdog_cfg};
                `REG_CAN_CFG:
                    rdata <= (state == ST_FORCED) ? 8'h00 :
                             {3'h0, can_cfg};
                `REG_AUX_CFG:
                    rdata <= (state == ST_FORCED) ? 8'h00 :
                             {5'h00, aux_cfg};
                `REG_EVENT:
                    rdata <= {3'h0, events};
                `REG_EVENT_EN:
                    rdata <= (state == ST_FORCED) ? 8'h00 :
                             {5'h00, event_en};
                default:
                    rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // Mode-dependent outputs
    // ****************************************************************
    // Aux supply per mode
    reg next_aux;
    always @* begin
        next_aux = 1'b0;
        case (state)
            ST_NORMAL:
                next_aux = (aux_supply_control != 2'h0);
            ST_STANDBY:
                next_aux = aux_supply_control[1]; // RULE18
            ST_SLEEP:
                next_aux = (aux_supply_control == 2'h3); // RULE18
            ST_RESET:
                next_aux = aux_supply_startup_control ||
                           aux_supply_control[1]; // RULE17
            ST_FORCED:
                next_aux = 1'b1;
            default:
                next_aux = 1'b0;
        endcase
    end

    // Registered mode outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd <= 1'b1;
            reset_line_n_out <= 1'b0;
            reset_line_n_oe <= 1'b1;
            limp_n_out <= 1'b0;
            limp_n_oe <= 1'b0;
            main_regulator_en <= 1'b0;
            aux_supply_en <= 1'b0;
            can_tx_en <= 1'b0;
            can_rx_en <= 1'b0;
            bus_bias_2v5 <= 1'b0;
            watchdog_en <= 1'b0;
            watchdog_window <= 1'b0;
            spi_enable <= 1'b0;
            temp_protect_en <= 1'b0;
            mode_state <= ST_OFF;
        end else begin
            mode_state <= state;
            // Line low until the hold ends, so Reset can be left
            reset_line_n_out <= 1'b0;
            reset_line_n_oe <= !port_up && !(state == ST_RESET &&
                               mode_timer >= RESET_HOLD_CYC); // RULE15
            // Open drain: only ever pulls low
            limp_n_out <= 1'b0;
            limp_n_oe <= events[`EV_LIMP]; // RULE22
            main_regulator_en <= port_up || (state == ST_RESET); // RULE2
            aux_supply_en <= next_aux;
            // Transceiver in Normal with active config, and in Forced Normal
            can_tx_en <= (state == ST_NORMAL && can_active) ||
                         (state == ST_FORCED); // RULE3
            can_rx_en <= (state == ST_NORMAL && can_active) ||
                         (state == ST_FORCED); // RULE4
            watchdog_en <= wdog_cfg[0] && (state == ST_NORMAL ||
                           state == ST_STANDBY); // RULE16
            watchdog_window <= wdog_cfg[0] && wdog_cfg[1] &&
                               (state == ST_NORMAL); // RULE5
            spi_enable <= port_up; // RULE12
            temp_protect_en <= (state != ST_SLEEP) &&
                               (state != ST_OFF); // RULE10
            // Bus biasing
            if (state == ST_OFF || state == ST_OVERTEMP)
                bus_bias_2v5 <= 1'b0;
            else if (can_tx_en || state == ST_FORCED)
                bus_bias_2v5 <= 1'b1;
            else
                bus_bias_2v5 <= (silence_cnt != SILENCE_CYC); // RULE7
            // Bus data or wake flag
            if (can_rx_en && state == ST_NORMAL)
                rxd <= s_bus; // RULE21
            else if (can_rx_en && state == ST_FORCED)
                rxd <= s_bus;
            else
                rxd <= !(wake_pending || any_wake); // RULE9
        end
    end

endmodule

/* inc/sbc_mode_consts.vh */
/*
 * Mode controller constants: offsets, fields, codes, timing.
 * Assumes a 20 ns clock and an 8-bit register port.
 */
`ifndef SBC_MODE_CONSTS_VH
`define SBC_MODE_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_MODE_CTRL 8'h01
`define REG_MAIN_STAT 8'h03
`define REG_WDOG_CFG 8'h04
`define REG_CAN_CFG 8'h05
`define REG_AUX_CFG 8'h06
`define REG_EVENT 8'h07
`define REG_EVENT_EN 8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define EV_BUS_WAKE 0
`define EV_LOCAL_WAKE 1
`define EV_OVERTEMP 2
`define EV_SPI_FAIL 3
`define EV_LIMP 4
`define CAN_REMOTE_WAKE 2
`define CAN_PN_CONFIG 3
`define CAN_PN_VALID 4
`define AUX_STARTUP 2
`define STAT_ACCESS_OK 3

// ****************************************************************
// Mode command codes and reset values
// ****************************************************************
`define MODE_CMD_SLEEP 3'h1
`define MODE_CMD_STANDBY 3'h4
`define MODE_CMD_NORMAL 3'h7
`define CAN_MODE_ACTIVE 2'h1
`define RST_MODE_CTRL 3'h4
`define RST_CAN_CFG 5'h04
`define RST_AUX_CFG 3'h0
`define RST_EVENT_EN 3'h0
`define RST_WDOG_CFG 2'h0
`define RST_SYNC 9'h030

// ****************************************************************
// Timing figures
// ****************************************************************
`define CLK_NS 20
`define T_STARTUP_US 1000
`define T_RESET_HOLD_US 20000
`define T_ACCESS_TO_NS 45000
`define T_SILENCE_US 1000000
`define T_WAKE_DOM_NS 5000

`endif

/* verification/sbc_host_model.sv */
/* Host model: reset line pull-up and post-reset access wait.
   Assumes the line is pulled only through its enable. */
`timescale 1ns/100ps
module sbc_host_model #(
    parameter [31:0] ACCESS_CYC = 32'd2250
) (
    input wire clk,
    input wire rst_n,
    input wire line_oe,
    input wire line_out,
    output wire line_n,
    output reg access_ready
);
    reg [31:0] wait_cnt;
    // Pull-up
    assign line_n = line_oe ? line_out : 1'b1;
    // Access wait after the line rises
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || !line_n) begin
            wait_cnt <= 32'h0;
            access_ready <= 1'b0;
        end else if (wait_cnt < ACCESS_CYC + 32'h8) begin
            wait_cnt <= wait_cnt + 32'h1;
        end else begin
            access_ready <= 1'b1;
        end
    end
endmodule

/* verification/sbc_mode_sva.sv */
/* Port checker of the mode controller.
   Bound to every controller instance, sees its ports only. */
`timescale 1ns/100ps
module sbc_mode_sva #(
    parameter [31:0] RESET_HOLD_CYC = 32'h28,
    parameter [31:0] SILENCE_CYC = 32'h64
) (
    input wire clk,
    input wire rst_n,
    input wire rd,
    input wire [7:0] rdata,
    input wire bus_rx,
    input wire sleep_lockout,
    input wire rxd,
    input wire reset_line_n_oe,
    input wire limp_n_out,
    input wire limp_n_oe,
    input wire main_regulator_en,
    input wire can_tx_en,
    input wire can_rx_en,
    input wire bus_bias_2v5,
    input wire watchdog_en,
    input wire watchdog_window,
    input wire spi_enable,
    input wire temp_protect_en,
    input wire [2:0] mode_state
);
    reg [31:0] hold_cnt;
    reg [31:0] sil_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // Cycles in Reset mode and on a recessive bus
    // ****************************************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= 32'h0;
            sil_cnt <= 32'h0;
        end else begin
            hold_cnt <= (mode_state == 3'h1) ? hold_cnt + 32'h1 : 32'h0;
            if (!bus_rx)
                sil_cnt <= 32'h0;
            else if (sil_cnt < SILENCE_CYC + 32'h8)
                sil_cnt <= sil_cnt + 32'h1;
        end
    end
    sequence s_sleep_exit;
        mode_state == 3'h4 ##1 mode_state != 3'h4;
    endsequence
    sequence s_locked;
        sleep_lockout [*4];
    endsequence
    AST_SLEEP_OFF: assert property ($past(mode_state) == 3'h4 &&
        mode_state == 3'h4 |-> !main_regulator_en && !temp_protect_en
        && !spi_enable && !watchdog_en) else $error("sleep enables on");
    AST_RESET_ON: assert property ($past(mode_state) == 3'h1 &&
        mode_state == 3'h1 |-> (reset_line_n_oe ||
        hold_cnt >= RESET_HOLD_CYC) && main_regulator_en &&
        temp_protect_en && !spi_enable && !watchdog_en && !can_tx_en)
        else $error("reset outputs");
    AST_STANDBY: assert property ($past(mode_state) == 3'h2 &&
        mode_state == 3'h2 |-> !can_tx_en && !can_rx_en && spi_enable &&
        main_regulator_en && !watchdog_window) else $error("standby bad");
    AST_NORMAL: assert property ($past(mode_state) == 3'h3 &&
        mode_state == 3'h3 |-> main_regulator_en && spi_enable)
        else $error("normal");
    AST_LOCKOUT: assert property (s_locked ##0 mode_state != 3'h4
        |=> mode_state != 3'h4) else $error("locked sleep");
    AST_SLEEP_EXIT: assert property (s_sleep_exit |->
        mode_state == 3'h1) else $error("sleep exit");
    AST_WAKE_RXD: assert property (s_sleep_exit |-> ##[0:3] !rxd)
        else $error("wake rxd");
    AST_HOLD_LEN: assert property ($fell(mode_state == 3'h1) |->
        hold_cnt >= RESET_HOLD_CYC) else $error("hold short");
    AST_READ_BLOCK: assert property (rd && !spi_enable |=>
        rdata == 8'h00) else $error("read open");
    AST_BIAS_GND: assert property (mode_state == 3'h2 &&
        sil_cnt > SILENCE_CYC + 32'h6 |-> !bus_bias_2v5)
        else $error("bias gnd");
    AST_BIAS_UP: assert property (mode_state == 3'h2 &&
        $fell(bus_rx) |-> ##[1:6] bus_bias_2v5)
        else $error("bias up");
    AST_LIMP: assert property (limp_n_oe |-> !limp_n_out)
        else $error("limp");
endmodule
bind sbc_mode_controller sbc_mode_sva #(.RESET_HOLD_CYC(RESET_HOLD_CYC),
    .SILENCE_CYC(SILENCE_CYC)) u_sva (.*);

/* verification/test_sbc_mode_controller.sv */
/* Mode controller bench: boot, access, modes, lockout, wake.
   Assumes the host model. */
`timescale 1ns/100ps
module test_sbc_mode_controller;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg power_on_det = 1'b1;
    reg bus_rx = 1'b1;
    reg wake_pin = 1'b0;
    reg sleep_lockout = 1'b0;
    reg overtemp_warn = 1'b0;
    reg frame_match = 1'b0;
    reg [7:0] rv;
    wire [7:0] rdata;
    wire [2:0] mode_state;
    wire rxd, reset_line_n_out, reset_line_n_oe, main_regulator_en;
    wire can_tx_en, can_rx_en, bus_bias_2v5, watchdog_en, watchdog_window;
    wire spi_enable, temp_protect_en, line_n, ready;
    integer mismatches = 0;
    integer n_compared = 0;
    integer cycles = 0;
    integer i;
    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            give_verdict;
        end
    end
    sbc_mode_controller #(.STARTUP_CYC(20), .RESET_HOLD_CYC(40),
        .SILENCE_CYC(100)) DUT (.*, .overtemp_shut(1'b0),
        .forced_normal_cfg(1'b0),
        .reset_line_n_in(line_n), .limp_n_out(), .limp_n_oe(),
        .aux_supply_en());
    sbc_host_model u_host (.clk(clk), .rst_n(rst_n),
        .line_oe(reset_line_n_oe), .line_out(reset_line_n_out),
        .line_n(line_n), .access_ready(ready));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 rv = rdata;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wait_on(input integer want_ready, input [2:0] m);
        begin
            i = 0;
            while (((want_ready != 0) ? ready !== 1'b1 : mode_state !== m)
                && i < 5000) begin
                @(posedge clk);
                #1 i = i + 1;
            end
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rv = $urandom(32'hB094);
        cyc(8);
        chk({6'h0, reset_line_n_oe, main_regulator_en}, 8'h02);
        rst_n <= 1'b1;
        wait_on(0, 3'h1);
        cyc(2);
        chk({5'h0, main_regulator_en, temp_protect_en, spi_enable}, 8'h06);
        chk({7'h0, line_n}, 8'h00);
        rd_reg(8'h03);
        chk(rv, 8'h00);
        wait_on(0, 3'h2);
        cyc(2);
        chk({5'h0, spi_enable, can_tx_en, can_rx_en}, 8'h04);
        wr_reg(8'h01, 8'h07);
        cyc(3);
        chk({5'h0, mode_state}, 8'h02);
        wait_on(1, 3'h0);
        rd_reg(8'h07);
        chk(rv & 8'h08, 8'h00);
        $display("boot test done");
        // Watchdog, Normal, bus data
        rd_reg(8'h03);
        chk(rv, 8'h0A);
        wr_reg(8'h04, 8'h03);
        cyc(3);
        chk({6'h0, watchdog_en, watchdog_window}, 8'h02);
        wr_reg(8'h05, 8'h05);
        wr_reg(8'h01, 8'h07);
        cyc(3);
        chk({4'h3, watchdog_window, can_tx_en, can_rx_en, main_regulator_en},
            8'h3F);
        for (i = 0; i < 8; i = i + 1) begin
            bus_rx <= $urandom % 2;
            cyc(5);
            chk({7'h0, rxd}, {7'h0, bus_rx});
        end
        bus_rx <= 1'b1;
        $display("normal test done");
        // Mode codes 2, 3, 6 refused, Normal code 7 kept
        for (i = 0; i < 6; i = i + 1) begin
            wr_reg(8'h01, 8'h02 | ($urandom % 2) | ($urandom % 2) << 2);
            rd_reg(8'h01);
            chk(rv, 8'h07);
        end
        // Sleep lockout
        sleep_lockout <= 1'b1;
        wr_reg(8'h07, 8'h1F);
        wr_reg(8'h01, 8'h04);
        wr_reg(8'h01, 8'h01);
        cyc(3);
        chk({5'h0, mode_state}, 8'h02);
        rd_reg(8'h07);
        chk(rv & 8'h08, 8'h08);
        wr_reg(8'h07, 8'h1F);
        sleep_lockout <= 1'b0;
        $display("lockout test done");
        // Bus wake and silence
        bus_rx <= 1'b0;
        cyc(300);
        chk({6'h0, rxd, bus_bias_2v5}, 8'h01);
        bus_rx <= 1'b1;
        cyc(115);
        chk({6'h0, rxd, bus_bias_2v5}, 8'h00);
        wr_reg(8'h08, 8'h06);
        overtemp_warn <= 1'b1;
        wr_reg(8'h07, 8'h01);
        cyc(4);
        chk({7'h0, rxd}, 8'h00);
        wr_reg(8'h07, 8'h04);
        cyc(4);
        chk({7'h0, rxd}, 8'h01);
        // Sleep and local wake
        wr_reg(8'h08, 8'h02);
        wr_reg(8'h01, 8'h01);
        cyc(3);
        chk({mode_state, main_regulator_en, temp_protect_en, spi_enable,
            watchdog_en, line_n}, 8'h80);
        wake_pin <= 1'b1;
        wait_on(0, 3'h1);
        cyc(2);
        chk({7'h0, rxd}, 8'h00);
        wake_pin <= 1'b0;
        wait_on(1, 3'h0);
        chk({4'h0, mode_state, rxd}, 8'h04);
        wr_reg(8'h07, 8'h02);
        cyc(4);
        chk({7'h0, rxd}, 8'h01);
        $display("sleep test done");
        give_verdict;
    end
endmodule
